// [hw/pms_pkg.sv]
package pms_pkg;
  // ----------------------------------------------------------------
  // port addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] PORT_POWER_CTRL = 16'h1872;
  localparam logic [15:0] PORT_OUT_LATCH = 16'h7072;
  localparam logic [15:0] PORT_INPUTS = 16'h8872;
  localparam logic [15:0] PORT_NMI_STATUS = 16'h9072;
  localparam logic [15:0] PORT_IRQ_STATE = 16'hA072;
  localparam logic [15:0] PORT_ACT_CTRL = 16'hB072;
  localparam logic [15:0] PORT_INT_ENABLE = 16'hC872;
  localparam logic [15:0] PORT_LOCK = 16'hF073;
  localparam logic [15:0] UNLOCK_KEY = 16'h00A5;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PWR_DOWN_BIT = 13;
  localparam int OUT_LOCAL_ACKNOWLEDGE = 3;
  localparam int OUT_ATTENTION = 4;
  localparam int OUT_CPU_DOWN = 5;
  localparam int IN_POWER_GOOD = 1;
  localparam int IN_LOCAL_REQUEST = 2;
  localparam int LOCAL_REQUEST_ENABLE_BIT = 14;
  localparam int ACT_ENABLE = 0;
  localparam int ACT_FINE = 1;
  localparam int ACT_PERIOD_LSB = 4;
  localparam int ACT_BEFORE = 8;
  localparam int ACT_DMA_BUSY = 9;
  localparam int ACT_ATTN = 10;
  localparam int OPC_DIR = 7;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam longint FINE_TICK_PS = 64'd7812500000;
  localparam longint POWER_UP_WAIT_PS = 64'd1000000000;
  localparam int FINE_TICK_CYC = int'(FINE_TICK_PS / CLK_PERIOD_PS);
  localparam int POWER_UP_CYC = int'(POWER_UP_WAIT_PS / CLK_PERIOD_PS);
  localparam int FINE_PER_COARSE = 8192;
  localparam int RESET_TAIL_CLKS = 64;
  localparam logic [3:0] RESET_PULSE_CYC = 4'h8;
  localparam logic [2:0] STROBE_CYC = 3'h4;
  localparam logic [1:0] SCAN_HOLD = 2'h3;
  // ----------------------------------------------------------------
  // carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } pms_io_req_t;
  typedef struct packed {
    logic [7:0] edOut;
    logic edOe;
    logic latchStrobe;
    logic kbcRdStrobe;
    logic kbcWrStrobe;
  } pms_ext_bus_t;
  typedef enum logic [2:0] {
    PD_RUN = 3'b000, PD_RESET = 3'b001, PD_PARK = 3'b010,
    PD_WAIT = 3'b011, PD_CHECK = 3'b100, PD_RELEASE = 3'b101
  } pms_pd_state_t;
  typedef enum logic [3:0] {
    L_IDLE = 4'b0000, L_HOLD = 4'b0001, L_ACK = 4'b0010,
    L_OP = 4'b0011, L_WREQ = 4'b0100, L_HI = 4'b0101,
    L_LO = 4'b0110, L_DONE = 4'b0111
  } pms_lcl_state_t;
endpackage

// [hw/pms_power_mgmt_sequencer.sv]
`timescale 1ns/1ns
// Functional notes
// - coarse inactivity period 64 s to 16 min
// - readable activity-before flag in control register
// - elapsed inactivity period raises local attention
// - fine timeout mode 7.8 to 117.2 ms
// - readable DMA-in-progress indication
// - interrupt controller state readable by software
// - bit 13 at 1872H starts power-down
// - reset asserted, then floated on power-down
// - output 5 switches processor power converter
// - parked CPU outputs held low while down
// - unmasked DMA, IRQ or NMI wakes CPU
// - after 1 ms check power-good, restore outputs
// - reset held 64 more CPU clocks
// - outputs latched from data bus, input muxed
// - local request seen as input 2, recorded
// - arbitrate hold, then assert local acknowledge
// - read opcode byte, drop local acknowledge
// - data moves high byte then low byte
// - write: read high, low, then write register
// - local accesses bypass register lock
// - direction 1 read/IOW, 0 write/IOR
// - input 2 is request only when enabled
// - local attention drives output 4
module pms_power_mgmt_sequencer import pms_pkg::*; #(
  parameter int FINE_TICK = FINE_TICK_CYC,
  parameter int POWER_UP_WAIT = POWER_UP_CYC,
  parameter int COARSE_UNIT = FINE_PER_COARSE
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire pms_io_req_t ioReq,
  output logic [15:0] ioRdData,
  input wire logic powerInputLine,
  output logic [2:0] inputSelect,
  input wire logic [7:0] edIn,
  output pms_ext_bus_t extBus,
  input wire logic dmaRequest,
  input wire logic irqRequest,
  input wire logic activityEvent,
  input wire logic dmaActive,
  input wire logic [15:0] irqState,
  input wire logic cpuReadyIn,
  input wire logic holdAckIn,
  output logic cpuResetOut,
  output logic cpuResetOe,
  output logic cpuClockOut,
  output logic cpuReady,
  output logic cpuHold,
  output logic cpuInterruptRequest,
  output logic cpuNmi
);
  initial begin
    if (FINE_TICK < 2 || POWER_UP_WAIT < 2 || COARSE_UNIT < 1)
      $error("pms: timing parameters too small");
  end
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic pinMeta, pinSync, ackMeta, ackSync;
  logic [7:0] edMeta, edSync;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      {pinMeta, pinSync, ackMeta, ackSync} <= 4'h0;
      {edMeta, edSync} <= 16'h0000;
    end else begin
      pinMeta <= powerInputLine;
      pinSync <= pinMeta;
      ackMeta <= holdAckIn;
      ackSync <= ackMeta;
      edMeta <= edIn;
      edSync <= edMeta;
    end
  end
  // ----------------------------------------------------------------
  // input multiplexer scan
  // ----------------------------------------------------------------
  // each select is held long enough for the synchroniser to settle
  logic [1:0] scanCnt;
  logic [7:0] inStatus, inPrev;
  wire scanSample = (scanCnt == SCAN_HOLD);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      scanCnt <= 2'h0;
      inputSelect <= 3'h0;
      inStatus <= 8'h00;
      inPrev <= 8'h00;
    end else begin
      scanCnt <= scanCnt + 2'h1;
      inPrev <= inStatus;
      if (scanSample) begin
        inStatus[inputSelect] <= pinSync;
        inputSelect <= inputSelect + 3'h1;
      end
    end
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] powerCtrl, inputsCtrl, intEnable, actCtrl, nmiStatus;
  logic unlocked;
  logic [7:0] outBits, latched;
  logic lclWr;
  logic [2:0] lclIdx;
  logic [15:0] lclData;
  function automatic logic [15:0] portOf(input logic [2:0] idx);
    case (idx)
      3'h0: portOf = PORT_POWER_CTRL;
      3'h1: portOf = PORT_OUT_LATCH;
      3'h2: portOf = PORT_INPUTS;
      3'h3: portOf = PORT_NMI_STATUS;
      3'h4: portOf = PORT_IRQ_STATE;
      3'h5: portOf = PORT_ACT_CTRL;
      default: portOf = PORT_INT_ENABLE;
    endcase
  endfunction
  wire [15:0] wrAddr = lclWr ? portOf(lclIdx) : ioReq.addr;
  wire [15:0] wrData = lclWr ? lclData : ioReq.wdata;
  wire wrAny = lclWr || ioReq.wr;
  wire wrPower = wrAny && wrAddr == PORT_POWER_CTRL
    && (lclWr || unlocked);
  wire wrInputs = wrAny && wrAddr == PORT_INPUTS;
  wire wrNmi = wrAny && wrAddr == PORT_NMI_STATUS;
  wire wrAct = wrAny && wrAddr == PORT_ACT_CTRL;
  wire wrIntEn = wrAny && wrAddr == PORT_INT_ENABLE;
  wire rdAct = ioReq.rd && ioReq.addr == PORT_ACT_CTRL;
  wire lclEnabled = inputsCtrl[LOCAL_REQUEST_ENABLE_BIT];
  wire lclReq = lclEnabled && inStatus[IN_LOCAL_REQUEST];
  wire [7:0] inChange = inStatus ^ inPrev;
  wire [5:0] nmiSet = inChange[7:2] & intEnable[15:10];
  logic activityBefore, attention;
  function automatic logic [15:0] readOf(input logic [15:0] a,
      input logic [15:0] act, input logic [15:0] ins);
    if (a == PORT_POWER_CTRL) readOf = powerCtrl;
    else if (a == PORT_OUT_LATCH) readOf = {8'h00, latched};
    else if (a == PORT_INPUTS) readOf = ins;
    else if (a == PORT_NMI_STATUS) readOf = nmiStatus;
    else if (a == PORT_IRQ_STATE) readOf = irqState;
    else if (a == PORT_ACT_CTRL) readOf = act;
    else if (a == PORT_INT_ENABLE) readOf = intEnable;
    else readOf = 16'h0000;
  endfunction
  wire [15:0] actView = {actCtrl[15:11], attention, dmaActive,
    activityBefore, actCtrl[7:0]};
  wire [15:0] insView = {inputsCtrl[15:8], inStatus};
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      powerCtrl <= 16'h0000;
      inputsCtrl <= 16'h0000;
      intEnable <= 16'h0000;
      actCtrl <= 16'h0000;
      nmiStatus <= 16'h0000;
      unlocked <= 1'b0;
      ioRdData <= 16'h0000;
    end else begin
      if (wrPower) powerCtrl <= wrData;
      else powerCtrl[PWR_DOWN_BIT] <= 1'b0;
      if (wrInputs) inputsCtrl <= {wrData[15:14], 14'h0000};
      if (wrIntEn) intEnable <= {wrData[15:10], 2'h0, wrData[7:2], 2'h0};
      if (wrAct) actCtrl <= wrData;
      // set wins over a write-one-to-clear in the same cycle
      nmiStatus[7:2] <= (nmiStatus[7:2] & ~(wrNmi ? wrData[7:2] : 6'h00))
        | nmiSet;
      if (ioReq.wr && ioReq.addr == PORT_LOCK)
        unlocked <= (ioReq.wdata == UNLOCK_KEY);
      if (ioReq.rd) ioRdData <= readOf(ioReq.addr, actView, insView);
    end
  end
  // ----------------------------------------------------------------
  // activity monitor
  // ----------------------------------------------------------------
  // coarse period n counts n*64 s, fine period n counts n*7.8125 ms
  logic [31:0] preCnt;
  logic [19:0] tickCnt;
  wire actEnable = actCtrl[ACT_ENABLE];
  wire [3:0] period = actCtrl[ACT_PERIOD_LSB +: 4];
  wire [19:0] unitTicks = actCtrl[ACT_FINE] ? 20'h00001
    : 20'(COARSE_UNIT);
  wire [19:0] limit = 20'(period * unitTicks);
  wire activity = dmaRequest || irqRequest || activityEvent;
  wire fineTick = (preCnt == 32'(FINE_TICK - 1));
  wire expire = actEnable && period != 4'h0 && fineTick
    && tickCnt + 20'h00001 >= limit;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      preCnt <= 32'h00000000;
      tickCnt <= 20'h00000;
      activityBefore <= 1'b0;
      attention <= 1'b0;
    end else begin
      preCnt <= (fineTick || activity || !actEnable) ? 32'h00000000
        : preCnt + 32'h00000001;
      if (activity || !actEnable || expire) tickCnt <= 20'h00000;
      else if (fineTick) tickCnt <= tickCnt + 20'h00001;
      // a read clears the flag unless activity lands in that cycle
      activityBefore <= activity || (activityBefore && !rdAct);
      attention <= expire || (attention
        && !(wrAct && wrData[ACT_ATTN]));
    end
  end
  // ----------------------------------------------------------------
  // processor power-down and power-up
  // ----------------------------------------------------------------
  pms_pd_state_t pdState;
  logic [31:0] pdCnt;
  logic cpuDown;
  wire wake = dmaRequest || irqRequest || (|nmiStatus[7:2]);
  wire pdDone = (pdCnt == 32'h00000000);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pdState <= PD_RUN;
      pdCnt <= 32'h00000000;
      cpuDown <= 1'b0;
      cpuResetOut <= 1'b1;
      cpuResetOe <= 1'b1;
      cpuClockOut <= 1'b0;
    end else begin
      cpuClockOut <= (pdState == PD_RUN || pdState == PD_RELEASE)
        ? !cpuClockOut : 1'b0;
      if (!pdDone) pdCnt <= pdCnt - 32'h00000001;
      case (pdState)
        PD_RUN: begin
          cpuResetOut <= 1'b0;
          if (powerCtrl[PWR_DOWN_BIT]) begin
            pdState <= PD_RESET;
            cpuResetOut <= 1'b1;
            pdCnt <= 32'(RESET_PULSE_CYC);
          end
        end
        PD_RESET: if (pdDone) begin
          cpuResetOe <= 1'b0;
          cpuDown <= 1'b1;
          pdState <= PD_PARK;
        end
        PD_PARK: if (wake) begin
          cpuDown <= 1'b0;
          pdCnt <= 32'(POWER_UP_WAIT - 1);
          pdState <= PD_WAIT;
        end
        PD_WAIT: if (pdDone) pdState <= PD_CHECK;
        PD_CHECK: if (inStatus[IN_POWER_GOOD]) begin
          cpuResetOe <= 1'b1;
          cpuResetOut <= 1'b1;
          pdCnt <= 32'(2 * RESET_TAIL_CLKS - 1);
          pdState <= PD_RELEASE;
        end else begin
          pdCnt <= 32'(POWER_UP_WAIT - 1);
          pdState <= PD_WAIT;
        end
        PD_RELEASE: if (pdDone) begin
          cpuResetOut <= 1'b0;
          pdState <= PD_RUN;
        end
        default: pdState <= PD_RUN;
      endcase
    end
  end
  wire cpuLive = (pdState == PD_RUN || pdState == PD_RELEASE);
  // ----------------------------------------------------------------
  // local access handshake and external bus
  // ----------------------------------------------------------------
  pms_lcl_state_t lclState;
  logic [2:0] strobeCnt;
  logic [7:0] opcode;
  logic [7:0] hiByte;
  logic lclAck, holdReq;
  assign outBits = {2'h0, cpuDown, attention, lclAck, 3'h0};
  wire latchDue = (outBits != latched) && strobeCnt == 3'h0;
  wire busFree = strobeCnt == 3'h0 && !latchDue;
  wire strobeEnd = strobeCnt == 3'h1;
  wire dirRead = opcode[OPC_DIR];
  wire [15:0] rdWord = readOf(portOf(opcode[2:0]), actView, insView);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lclState <= L_IDLE;
      strobeCnt <= 3'h0;
      opcode <= 8'h00;
      hiByte <= 8'h00;
      lclAck <= 1'b0;
      holdReq <= 1'b0;
      lclWr <= 1'b0;
      lclIdx <= 3'h0;
      lclData <= 16'h0000;
      latched <= 8'h00;
      extBus <= '0;
    end else begin
      lclWr <= 1'b0;
      if (strobeCnt != 3'h0) strobeCnt <= strobeCnt - 3'h1;
      if (strobeEnd) extBus <= '0;
      if (latchDue) begin
        latched <= outBits;
        extBus <= '{edOut: outBits, edOe: 1'b1, latchStrobe: 1'b1,
          kbcRdStrobe: 1'b0, kbcWrStrobe: 1'b0};
        strobeCnt <= STROBE_CYC;
      end
      case (lclState)
        L_IDLE: if (lclReq && pdState == PD_RUN) begin
          holdReq <= 1'b1;
          lclState <= L_HOLD;
        end
        L_HOLD: if (ackSync) begin
          lclAck <= 1'b1;
          lclState <= L_ACK;
        end
        L_ACK: if (!lclReq && busFree) begin
          extBus.kbcRdStrobe <= 1'b1;
          strobeCnt <= STROBE_CYC;
          lclState <= L_OP;
        end
        L_OP: if (strobeEnd) begin
          opcode <= edSync;
          lclAck <= 1'b0;
          lclState <= L_WREQ;
        end
        L_WREQ: if (lclReq && busFree) begin
          strobeCnt <= STROBE_CYC;
          extBus.edOe <= dirRead;
          extBus.edOut <= rdWord[15:8];
          extBus.kbcWrStrobe <= dirRead;
          extBus.kbcRdStrobe <= !dirRead;
          lclState <= L_HI;
        end
        L_HI: if (strobeEnd) lclState <= L_LO;
        L_LO: if (busFree) begin
          hiByte <= edSync;
          strobeCnt <= STROBE_CYC;
          extBus.edOe <= dirRead;
          extBus.edOut <= rdWord[7:0];
          extBus.kbcWrStrobe <= dirRead;
          extBus.kbcRdStrobe <= !dirRead;
          lclState <= L_DONE;
        end
        L_DONE: begin
          if (strobeEnd) lclData <= {hiByte, edSync};
          // stay until the request has left the scan, or it restarts
          if (strobeCnt == 3'h0 && !lclReq) begin
            lclWr <= !dirRead;
            lclIdx <= opcode[2:0];
            holdReq <= 1'b0;
            lclState <= L_IDLE;
          end
        end
        default: lclState <= L_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // processor-facing outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpuReady <= 1'b0;
      cpuHold <= 1'b0;
      cpuInterruptRequest <= 1'b0;
      cpuNmi <= 1'b0;
    end else begin
      cpuReady <= cpuLive && cpuReadyIn;
      cpuHold <= cpuLive && holdReq;
      cpuInterruptRequest <= cpuLive && irqRequest;
      cpuNmi <= cpuLive && (|nmiStatus[7:2]);
    end
  end
endmodule

// [tb/pms_far_side.sv]
`timescale 1ns/1ns
module pms_far_side import pms_pkg::*; (
  input wire logic sys_clk,
  input wire pms_ext_bus_t extBus,
  input wire logic [2:0] inputSelect,
  input wire logic cpuHold,
  input wire logic powerGood,
  output logic powerInputLine,
  output logic [7:0] edIn,
  output logic holdAckIn,
  output logic [7:0] outLatch
);
  logic localRequest = 1'b0;
  logic [7:0] kbcData = 8'h00;
  logic [7:0] holdLine = 8'h00;
  logic [7:0] wrByte = 8'h00;
  logic prevIow = 1'b0;
  logic timedOut = 1'b0;
  logic [2:0] ackLag = 3'h0;
  logic [7:0] got[$];
  // ------
  // latch, mux and host hold answer
  // ------
  initial outLatch = 8'h00;
  always @(posedge sys_clk) begin
    if (extBus.latchStrobe) outLatch <= extBus.edOut;
    holdLine <= {holdLine[6:0], cpuHold};
    prevIow <= extBus.kbcWrStrobe;
    if (extBus.kbcWrStrobe) wrByte <= extBus.edOut;
    if (prevIow && !extBus.kbcWrStrobe) got.push_back(wrByte);
  end
  // lag lets the host answer promptly or slowly
  assign holdAckIn = holdLine[ackLag];
  // unused mux inputs sit on pull-downs
  assign powerInputLine = {5'h00, localRequest, powerGood, 1'b0}[inputSelect];
  // shared bus: device drive wins, else keyboard controller register
  assign edIn = extBus.edOe ? extBus.edOut : kbcData;
  function automatic logic pick(input int w);
    return (w == 0) ? outLatch[OUT_LOCAL_ACKNOWLEDGE] :
      (w == 1) ? extBus.kbcRdStrobe :
      (w == 2) ? extBus.kbcWrStrobe : cpuHold;
  endfunction
  task automatic waitFor(input int w, input logic lvl);
    int n;
    n = 0;
    while (pick(w) !== lvl && n < 600) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 600) timedOut = 1'b1;
  endtask
  task automatic access(input logic [7:0] opc, input logic [15:0] d);
    int s;
    s = opc[OPC_DIR] ? 2 : 1;
    localRequest = 1'b1;
    waitFor(0, 1'b1);
    kbcData = opc;
    localRequest = 1'b0;
    waitFor(0, 1'b0);
    kbcData = d[15:8];
    localRequest = 1'b1;
    waitFor(s, 1'b1);
    waitFor(s, 1'b0);
    kbcData = d[7:0];
    waitFor(s, 1'b1);
    waitFor(s, 1'b0);
    localRequest = 1'b0;
    waitFor(3, 1'b0);
  endtask
endmodule

// [tb/pms_power_mgmt_sequencer_bench.sv]
`timescale 1ns/1ns
`define CHK(what, exp, got) begin \
  nCompared++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("unexpected %s: expected %h, seen %h", what, exp, got); \
  end \
end
module pms_power_mgmt_sequencer_bench import pms_pkg::*; ;
  localparam int FT = 4;
  localparam int PUW = 20;
  localparam int CU = 2;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  pms_io_req_t ioReq = '0;
  logic [15:0] ioRdData, irqState = 16'h0000, d;
  logic [7:0] edIn, outLatch;
  logic [2:0] inputSelect;
  pms_ext_bus_t extBus;
  logic powerInputLine, holdAckIn, powerGood = 1'b1, cpuReadyIn = 1'b1;
  logic dmaRequest = 1'b0, irqRequest = 1'b0, activityEvent = 1'b0;
  logic dmaActive = 1'b0, cpuResetOut, cpuResetOe, cpuClockOut;
  logic cpuReady, cpuHold, cpuInterruptRequest, cpuNmi;
  int errors = 0, nCompared = 0, n;
  pms_power_mgmt_sequencer #(.FINE_TICK(FT), .POWER_UP_WAIT(PUW),
    .COARSE_UNIT(CU)) DUT (.sys_clk(sys_clk), .reset_n(reset_n),
    .ioReq(ioReq), .ioRdData(ioRdData), .powerInputLine(powerInputLine),
    .inputSelect(inputSelect), .edIn(edIn), .extBus(extBus),
    .dmaRequest(dmaRequest), .irqRequest(irqRequest),
    .activityEvent(activityEvent), .dmaActive(dmaActive),
    .irqState(irqState), .cpuReadyIn(cpuReadyIn), .holdAckIn(holdAckIn),
    .cpuResetOut(cpuResetOut), .cpuResetOe(cpuResetOe),
    .cpuClockOut(cpuClockOut), .cpuReady(cpuReady), .cpuHold(cpuHold),
    .cpuInterruptRequest(cpuInterruptRequest), .cpuNmi(cpuNmi));
  pms_far_side far (.sys_clk(sys_clk), .extBus(extBus),
    .inputSelect(inputSelect), .cpuHold(cpuHold), .powerGood(powerGood),
    .powerInputLine(powerInputLine), .edIn(edIn), .holdAckIn(holdAckIn),
    .outLatch(outLatch));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  // ------
  // shared tasks
  // ------
  task automatic close_out();
    $display("compared %0d, errors %0d", nCompared, errors);
    if (errors == 0 && nCompared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  // a strobe is dropped for one idle cycle so requests never merge
  task automatic regWr(input logic [15:0] a, input logic [15:0] v);
    ioReq = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
    tick();
    ioReq.wr = 1'b0;
    tick();
  endtask
  task automatic regRd(input logic [15:0] a);
    ioReq = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
    tick();
    ioReq.rd = 1'b0;
    d = ioRdData;
    tick();
  endtask
  function automatic logic probe(input int w);
    case (w)
      0: return cpuResetOe;
      1: return outLatch[OUT_ATTENTION];
      2: return cpuResetOut;
      default: return outLatch[OUT_CPU_DOWN];
    endcase
  endfunction
  task automatic waitSig(input int w, input logic lvl);
    n = 0;
    while (probe(w) !== lvl && n < 2000) begin
      tick();
      n++;
    end
    if (n == 2000 || far.timedOut) begin
      errors++;
      $display("unexpected wait %0d: expected %b, seen timeout", w, lvl);
      close_out();
    end
  endtask
  // ------
  // scenarios
  // ------
  task automatic actRun(input logic fine, input logic [3:0] per, int minC);
    regWr(PORT_ACT_CTRL, {8'h00, per, 2'b00, fine, 1'b1});
    waitSig(1, 1'b1);
    `CHK("attention delay", 1'b1, n >= minC)
    regRd(PORT_ACT_CTRL);
    `CHK("attention flag", 1'b1, d[ACT_ATTN])
    regWr(PORT_ACT_CTRL, 16'h0400);
    waitSig(1, 1'b0);
  endtask
  task automatic actBefore();
    regWr(PORT_ACT_CTRL, 16'h00F3);
    activityEvent = 1'b1;
    tick();
    activityEvent = 1'b0;
    regRd(PORT_ACT_CTRL);
    `CHK("activity before", 1'b1, d[ACT_BEFORE])
    regRd(PORT_ACT_CTRL);
    `CHK("activity before cleared", 1'b0, d[ACT_BEFORE])
    regWr(PORT_ACT_CTRL, 16'h0400);
  endtask
  task automatic localLink();
    far.localRequest = 1'b1;
    repeat (60) tick();
    regRd(PORT_INPUTS);
    `CHK("request status", 1'b1, d[IN_LOCAL_REQUEST])
    `CHK("hold while disabled", 1'b0, cpuHold)
    far.localRequest = 1'b0;
    repeat (60) tick();
    regWr(PORT_INPUTS, 16'h4000);
    irqState = 16'hBEEF;
    far.got.delete();
    far.access(8'h84, 16'h0000);
    `CHK("bytes returned", 2, far.got.size())
    `CHK("read data", 16'hBEEF, {far.got[0], far.got[1]})
    far.ackLag = 3'h6;
    far.access(8'h06, 16'h8080);
    regRd(PORT_INT_ENABLE);
    `CHK("local write", 16'h8080, d)
    `CHK("link stuck", 1'b0, far.timedOut)
  endtask
  task automatic powerCycle();
    regWr(PORT_POWER_CTRL, 16'h2000);
    repeat (30) tick();
    `CHK("locked power write", 1'b1, cpuResetOe)
    far.access(8'h00, 16'h2000);
    waitSig(0, 1'b0);
    powerGood = 1'b0;
    waitSig(3, 1'b1);
    repeat (40) tick();
    irqRequest = 1'b1;
    waitSig(3, 1'b0);
    irqRequest = 1'b0;
    repeat (3 * PUW) tick();
    `CHK("parked without power good", 1'b0, cpuResetOe)
    powerGood = 1'b1;
    waitSig(0, 1'b1);
    `CHK("reset driven high", 1'b1, cpuResetOut)
    waitSig(2, 1'b0);
    `CHK("reset tail", 1'b1, n >= 124 && n <= 132)
    regWr(PORT_LOCK, UNLOCK_KEY);
    regWr(PORT_POWER_CTRL, 16'h2000);
    waitSig(0, 1'b0);
    dmaRequest = 1'b1;
    tick();
    dmaRequest = 1'b0;
    waitSig(0, 1'b1);
    `CHK("power good wait", 1'b1, n >= PUW)
    waitSig(3, 1'b0);
  endtask
  initial begin
    repeat (30000) @(posedge sys_clk);
    errors++;
    $display("unexpected run length: expected end, seen timeout");
    close_out();
  end
  initial begin
    repeat (8) tick();
    `CHK("reset level", 2'b11, {cpuResetOut, cpuResetOe})
    `CHK("latch at power on", 8'h00, outLatch)
    reset_n = 1'b1;
    tick();
    regRd(16'h1234);
    `CHK("unmapped read", 16'h0000, d)
    irqState = 16'hA55A;
    dmaActive = 1'b1;
    regRd(PORT_IRQ_STATE);
    `CHK("irq state", 16'hA55A, d)
    regRd(PORT_ACT_CTRL);
    `CHK("dma busy", 1'b1, d[ACT_DMA_BUSY])
    dmaActive = 1'b0;
    actRun(1'b1, 4'hF, 15 * FT);
    actRun(1'b0, 4'h1, CU * FT);
    actRun(1'b0, 4'hF, 15 * CU * FT);
    actBefore();
    localLink();
    powerCycle();
    close_out();
  end
endmodule

// [tb/pms_seq_asserts.sv]
`timescale 1ns/1ns
module pms_seq_asserts import pms_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire pms_io_req_t ioReq,
  input wire logic [15:0] ioRdData,
  input wire logic [2:0] inputSelect,
  input wire pms_ext_bus_t extBus,
  input wire logic dmaActive,
  input wire logic [15:0] irqState,
  input wire logic cpuResetOut,
  input wire logic cpuResetOe,
  input wire logic cpuClockOut,
  input wire logic cpuReady,
  input wire logic cpuHold,
  input wire logic cpuInterruptRequest,
  input wire logic cpuNmi
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ------
  // strobes
  // ------
  sequence s_latch4;
    (extBus.latchStrobe && extBus.edOe)[*4] ##1 !extBus.latchStrobe;
  endsequence
  sequence s_ior4;
    (extBus.kbcRdStrobe && !extBus.edOe)[*4] ##1 !extBus.kbcRdStrobe;
  endsequence
  a_latch_drive: assert property ($rose(extBus.latchStrobe) |-> s_latch4)
    else $error("latch strobe shape wrong");
  a_ior_floats: assert property ($rose(extBus.kbcRdStrobe) |-> s_ior4)
    else $error("read strobe shape wrong");
  a_iow_drives: assert property (extBus.kbcWrStrobe |-> extBus.edOe && cpuHold)
    else $error("write strobe without bus drive");
  a_hold_covers: assert property (extBus.kbcRdStrobe |-> cpuHold)
    else $error("read strobe outside hold");
  a_scan_hold: assert property ($changed(inputSelect) |=> $stable(inputSelect)[*3])
    else $error("mux select held too briefly");
  // ------
  // processor side
  // ------
  a_parked_low: assert property (!cpuResetOe |-> !(cpuClockOut || cpuReady
      || cpuHold || cpuInterruptRequest || cpuNmi))
    else $error("cpu output live while parked");
  a_pulse_float: assert property ($fell(cpuResetOe) |->
      $past(cpuResetOut) && $past(cpuResetOut, 8))
    else $error("reset floated without pulse");
  a_tail_hold: assert property ($fell(cpuResetOut) && ($past(cpuClockOut)
      || $past(cpuClockOut, 2)) |-> $past(cpuResetOut, 120))
    else $error("reset tail too short");
  a_irq_readback: assert property (ioReq.rd && ioReq.addr == PORT_IRQ_STATE
      |=> ioRdData == $past(irqState))
    else $error("irq state readback wrong");
  a_dma_flag: assert property (ioReq.rd && ioReq.addr == PORT_ACT_CTRL
      |=> ioRdData[ACT_DMA_BUSY] == $past(dmaActive))
    else $error("dma flag readback wrong");
endmodule
bind pms_power_mgmt_sequencer pms_seq_asserts u_chk (.sys_clk(sys_clk),
  .reset_n(reset_n), .ioReq(ioReq), .ioRdData(ioRdData),
  .inputSelect(inputSelect), .extBus(extBus), .dmaActive(dmaActive),
  .irqState(irqState), .cpuResetOut(cpuResetOut), .cpuResetOe(cpuResetOe),
  .cpuClockOut(cpuClockOut), .cpuReady(cpuReady), .cpuHold(cpuHold),
  .cpuInterruptRequest(cpuInterruptRequest), .cpuNmi(cpuNmi));
